// *** hdl/cbr_tile.sv ***
/*
 Configurable 18-Kbit block RAM tile: two fabric ports, Wishbone setup.
 Assumes fabric logic on the same clock drives both ports; FIFO control,
 if any, is built outside the tile.
*/
`timescale 1ns/1ps
module cbr_tile
    import cbr_pkg::*;
#(
    parameter int ADDR_W = CBR_ADDR_W,
    parameter int DATA_W = CBR_ROW_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic a_en_i,
    input wire logic a_we_i,
    input wire logic [ADDR_W-1:0] a_addr_i,
    input wire logic [DATA_W-1:0] a_din_i,
    input wire logic [CBR_BE_W-1:0] a_be_i,
    output logic [DATA_W-1:0] a_dout_o,
    input wire logic b_en_i,
    input wire logic b_we_i,
    input wire logic [ADDR_W-1:0] b_addr_i,
    input wire logic [DATA_W-1:0] b_din_i,
    input wire logic [CBR_BE_W-1:0] b_be_i,
    output logic [DATA_W-1:0] b_dout_o
);

    // Mapping logic is written for exactly one tile
    if (ADDR_W != CBR_ADDR_W || DATA_W != CBR_ROW_W) begin : g_bad_params
        $error("cbr_tile: ADDR_W and DATA_W must match the tile geometry");
    end

    typedef struct packed {
        logic [CBR_CTRL_W-1:0] ctrl;
        logic refused;
        logic collided;
        cbr_inreg_t [1:0] inr;
        cbr_rdpipe_t [1:0] rp;
        logic [1:0] ovld;
        logic [1:0][CBR_ROW_W-1:0] opipe;
        logic [1:0][CBR_ROW_W-1:0] dout;
        logic ack;
        logic [31:0] dat;
    } cbr_state_t;

    cbr_state_t s_r;
    cbr_state_t s_nxt;

    logic [CBR_ROW_W-1:0] rdat [2];
    logic [1:0] en_in;
    logic [1:0] we_in;
    logic [ADDR_W-1:0] addr_in [2];
    logic [DATA_W-1:0] din_in [2];
    logic [CBR_BE_W-1:0] be_in [2];

    cbr_mode_t mode;
    cbr_width_t wid [2];
    logic [1:0] ore;
    logic cfg_bad;
    logic [1:0] rd_ok;
    logic [1:0] wr_ok;

    assign en_in[0] = a_en_i;
    assign en_in[1] = b_en_i;
    assign we_in[0] = a_we_i;
    assign we_in[1] = b_we_i;
    assign addr_in[0] = a_addr_i;
    assign addr_in[1] = b_addr_i;
    assign din_in[0] = a_din_i;
    assign din_in[1] = b_din_i;
    assign be_in[0] = a_be_i;
    assign be_in[1] = b_be_i;

    // Word mask for a port width; lanes of nine keep the parity bit
    function automatic logic [CBR_ROW_W-1:0] cbr_wmask(input cbr_width_t w);
        logic [CBR_ROW_W-1:0] m;
        m = '0;
        unique case (w)
            CBR_W1: m = 36'h0_0000_0001;
            CBR_W2: m = 36'h0_0000_0003;
            CBR_W4: m = 36'h0_0000_000F;
            CBR_W9: m = 36'h0_0000_01FF;
            CBR_W18: m = 36'h0_0003_FFFF;
            CBR_W36: m = 36'hF_FFFF_FFFF;
            default: m = '0;
        endcase
        return m;
    endfunction

    // Words a port offers at its width
    function automatic logic [15:0] cbr_depth(input cbr_width_t w);
        logic [15:0] d;
        d = '0;
        unique case (w)
            CBR_W1: d = CBR_MAX_WORDS;
            CBR_W2: d = CBR_MAX_WORDS >> 1;
            CBR_W4: d = CBR_MAX_WORDS >> 2;
            CBR_W9: d = CBR_MAX_WORDS >> 3;
            CBR_W18: d = CBR_MAX_WORDS >> 4;
            CBR_W36: d = CBR_MAX_WORDS >> 5;
            default: d = '0;
        endcase
        return d;
    endfunction

    // Maps one port request onto a row, a bit position and a write mask
    function automatic cbr_inreg_t cbr_map(
        input cbr_width_t w,
        input logic [ADDR_W-1:0] addr,
        input logic [DATA_W-1:0] din,
        input logic [CBR_BE_W-1:0] be,
        input logic rd,
        input logic wr,
        input logic oreg
    );
        cbr_inreg_t m;
        logic [ADDR_W-1:0] bitaddr;
        logic [CBR_ROW_W-1:0] lanes;
        logic [CBR_ROW_W-1:0] wm;
        m = '0;
        bitaddr = '0;
        wm = cbr_wmask(w);
        lanes = {{CBR_LANE_W{be[3]}}, {CBR_LANE_W{be[2]}}, {CBR_LANE_W{be[1]}}, {CBR_LANE_W{be[0]}}};
        m.rd = rd;
        m.wr = wr;
        m.wid = w;
        m.ore = oreg;
        unique case (w)
            CBR_W1, CBR_W2, CBR_W4: begin
                bitaddr = addr << w;
                m.row = bitaddr[13:5];
                m.pos = CBR_POS_W'(bitaddr[4:3]) * 6'd9 + CBR_POS_W'(bitaddr[2:0]);
            end
            CBR_W9: begin
                m.row = addr[10:2];
                m.pos = CBR_POS_W'(addr[1:0]) * 6'd9;
            end
            CBR_W18: begin
                m.row = addr[9:1];
                m.pos = addr[0] ? 6'd18 : 6'd0;
                wm = wm & lanes;
            end
            CBR_W36: begin
                m.row = addr[8:0];
                m.pos = 6'd0;
                wm = wm & lanes;
            end
            default: begin
                m.rd = 1'b0;
                m.wr = 1'b0;
            end
        endcase
        m.mask = wm << m.pos;
        m.wdat = (din & cbr_wmask(w)) << m.pos;
        return m;
    endfunction

    assign mode = cbr_mode_t'(s_r.ctrl[CBR_CTRL_MODE_LSB +: 2]);
    assign wid[0] = cbr_width_t'(s_r.ctrl[CBR_CTRL_WA_LSB +: 3]);
    assign wid[1] = cbr_width_t'(s_r.ctrl[CBR_CTRL_WB_LSB +: 3]);
    assign ore[0] = s_r.ctrl[CBR_CTRL_ORA_BIT];
    assign ore[1] = s_r.ctrl[CBR_CTRL_ORB_BIT];

    // 36 bits refused in true dual port
    always_comb begin
        cfg_bad = 1'b0;
        if (mode == CBR_MODE_RSV || wid[0] > CBR_W36 || wid[1] > CBR_W36) begin
            cfg_bad = 1'b1;
        end
        if (mode == CBR_MODE_TDP && (wid[0] == CBR_W36 || wid[1] == CBR_W36)) begin
            cfg_bad = 1'b1;
        end
    end

    always_comb begin
        rd_ok[0] = !cfg_bad && mode != CBR_MODE_PDP;
        wr_ok[0] = !cfg_bad;
        rd_ok[1] = !cfg_bad && mode != CBR_MODE_SP;
        wr_ok[1] = !cfg_bad && mode == CBR_MODE_TDP;
    end

    always_comb begin
        logic wb_req;
        logic [CBR_ROW_W-1:0] ext;
        logic refuse_now;
        logic clr_refuse;
        logic clr_coll;
        logic coll_now;
        wb_req = wb_cyc_i && wb_stb_i && !s_r.ack;
        ext = '0;
        refuse_now = 1'b0;
        clr_refuse = 1'b0;
        clr_coll = 1'b0;
        coll_now = 1'b0;
        s_nxt = s_r;

        for (int p = 0; p < 2; p++) begin
            // requests land in input registers first
            s_nxt.inr[p] = cbr_map(wid[p], addr_in[p], din_in[p], be_in[p],
                                   en_in[p] && !we_in[p] && rd_ok[p],
                                   en_in[p] && we_in[p] && wr_ok[p], ore[p]);
            if (en_in[p] && (we_in[p] ? !wr_ok[p] : !rd_ok[p])) begin
                refuse_now = 1'b1;
            end

            s_nxt.rp[p].vld = s_r.inr[p].rd;
            s_nxt.rp[p].pos = s_r.inr[p].pos;
            s_nxt.rp[p].wid = s_r.inr[p].wid;
            s_nxt.rp[p].ore = s_r.inr[p].ore;

            // same linear view on the read side
            ext = (rdat[p] >> s_r.rp[p].pos) & cbr_wmask(s_r.rp[p].wid);

            s_nxt.ovld[p] = s_r.rp[p].vld && s_r.rp[p].ore;
            if (s_r.rp[p].vld && s_r.rp[p].ore) begin
                s_nxt.opipe[p] = ext;
            end
            // output moves on read results only
            if (s_r.ovld[p]) begin
                s_nxt.dout[p] = s_r.opipe[p];
            end else if (s_r.rp[p].vld && !s_r.rp[p].ore) begin
                s_nxt.dout[p] = ext;
            end
        end

        // Same row, overlapping bits: port A wins, software is told
        coll_now = s_r.inr[0].wr && s_r.inr[1].wr && s_r.inr[0].row == s_r.inr[1].row
                   && (s_r.inr[0].mask & s_r.inr[1].mask) != '0;

        s_nxt.ack = wb_req;
        if (wb_req) begin
            s_nxt.dat = '0;
            if (wb_we_i) begin
                if (wb_adr_i == CBR_CTRL_OFS) begin
                    if (wb_sel_i[0]) begin
                        s_nxt.ctrl[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        s_nxt.ctrl[9:8] = wb_dat_i[9:8];
                    end
                end else if (wb_adr_i == CBR_STAT_OFS && wb_sel_i[0]) begin
                    clr_refuse = wb_dat_i[CBR_STAT_REFUSE_BIT];
                    clr_coll = wb_dat_i[CBR_STAT_COLL_BIT];
                end
            end else if (wb_adr_i == CBR_CTRL_OFS) begin
                s_nxt.dat = 32'(s_r.ctrl);
            end else if (wb_adr_i == CBR_STAT_OFS) begin
                s_nxt.dat[CBR_STAT_BAD_BIT] = cfg_bad;
                s_nxt.dat[CBR_STAT_REFUSE_BIT] = s_r.refused;
                s_nxt.dat[CBR_STAT_COLL_BIT] = s_r.collided;
            end else if (wb_adr_i == CBR_INFO_OFS) begin
                s_nxt.dat[CBR_INFO_DA_LSB +: 16] = cbr_depth(wid[0]);
                s_nxt.dat[CBR_INFO_DB_LSB +: 16] = cbr_depth(wid[1]);
            end
        end

        // New events beat a clear in the same cycle
        s_nxt.refused = (s_r.refused && !clr_refuse) || refuse_now;
        s_nxt.collided = (s_r.collided && !clr_coll) || coll_now;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.ctrl <= CBR_CTRL_RST;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    // one tile behind the input and output registers
    // storage only; no FIFO flags here
    cbr_tile_mem #(
        .ROWS(CBR_ROWS),
        .WIDTH(CBR_ROW_W),
        .AW(CBR_ROW_AW)
    ) u_mem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .a_en_i(s_r.inr[0].rd || s_r.inr[0].wr),
        .a_we_i(s_r.inr[0].wr),
        .a_row_i(s_r.inr[0].row),
        .a_mask_i(s_r.inr[0].mask),
        .a_wdat_i(s_r.inr[0].wdat),
        .a_rdat_o(rdat[0]),
        .b_en_i(s_r.inr[1].rd || s_r.inr[1].wr),
        .b_we_i(s_r.inr[1].wr),
        .b_row_i(s_r.inr[1].row),
        .b_mask_i(s_r.inr[1].mask),
        .b_wdat_i(s_r.inr[1].wdat),
        .b_rdat_o(rdat[1])
    );

    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = s_r.dat;
    assign a_dout_o = s_r.dout[0];
    assign b_dout_o = s_r.dout[1];

endmodule

// *** pkg/cbr_pkg.sv ***
/*
 Shared constants and types for the configurable block RAM tile.
 Assumes a single 100 MHz clock domain and a classic Wishbone register slave.
*/
// How it works
// - One 18-Kbit array, registered inputs and outputs
// - Single, true dual or pseudo dual port
// - Widths 1,2,4,9,18 per mode; 36 in single and pseudo dual port only
// - Every byte lane carries a ninth parity bit
// - Byte write enables at 18 and 36 bits
// - Each port picks its own width
// - Bits mapped linearly, word LSB to MSB
// - Inputs always registered; output register optional
// - Output changes on reads only, never writes
package cbr_pkg;

    // Array geometry
    localparam int CBR_TILE_BITS = 18432;
    localparam int CBR_ROWS = 512;
    localparam int CBR_ROW_W = 36;
    localparam int CBR_ROW_AW = 9;
    localparam int CBR_ADDR_W = 14;
    localparam int CBR_POS_W = 6;
    localparam int CBR_LANE_W = 9;
    localparam int CBR_BE_W = 4;

    // Register offsets (byte addresses)
    localparam logic [31:0] CBR_CTRL_OFS = 32'h0000_0000;
    localparam logic [31:0] CBR_STAT_OFS = 32'h0000_0004;
    localparam logic [31:0] CBR_INFO_OFS = 32'h0000_0008;

    // Control fields
    localparam int CBR_CTRL_W = 10;
    localparam int CBR_CTRL_MODE_LSB = 0;
    localparam int CBR_CTRL_WA_LSB = 2;
    localparam int CBR_CTRL_WB_LSB = 5;
    localparam int CBR_CTRL_ORA_BIT = 8;
    localparam int CBR_CTRL_ORB_BIT = 9;
    localparam logic [CBR_CTRL_W-1:0] CBR_CTRL_RST = 10'h0B4;

    // Status fields
    localparam int CBR_STAT_BAD_BIT = 0;
    localparam int CBR_STAT_REFUSE_BIT = 1;
    localparam int CBR_STAT_COLL_BIT = 2;

    // Info fields: words per port at the current width
    localparam int CBR_INFO_DA_LSB = 0;
    localparam int CBR_INFO_DB_LSB = 16;
    localparam logic [15:0] CBR_MAX_WORDS = 16'h4000;

    typedef enum logic [1:0] {
        CBR_MODE_SP,
        CBR_MODE_TDP,
        CBR_MODE_PDP,
        CBR_MODE_RSV
    } cbr_mode_t;

    typedef enum logic [2:0] {
        CBR_W1,
        CBR_W2,
        CBR_W4,
        CBR_W9,
        CBR_W18,
        CBR_W36,
        CBR_W_RSV6,
        CBR_W_RSV7
    } cbr_width_t;

    // One port's input register, already mapped onto the array
    typedef struct packed {
        logic rd;
        logic wr;
        logic [CBR_ROW_AW-1:0] row;
        logic [CBR_ROW_W-1:0] mask;
        logic [CBR_ROW_W-1:0] wdat;
        logic [CBR_POS_W-1:0] pos;
        cbr_width_t wid;
        logic ore;
    } cbr_inreg_t;

    // Read in flight between array and output
    typedef struct packed {
        logic vld;
        logic [CBR_POS_W-1:0] pos;
        cbr_width_t wid;
        logic ore;
    } cbr_rdpipe_t;

endpackage

// *** hdl/cbr_tile_mem.sv ***
/*
 Dual-port storage array of the block RAM tile with bit-granular write masks.
 Assumes the caller has already registered and mapped both ports' requests.
*/
`timescale 1ns/1ps
module cbr_tile_mem
    import cbr_pkg::*;
#(
    parameter int ROWS = CBR_ROWS,
    parameter int WIDTH = CBR_ROW_W,
    parameter int AW = CBR_ROW_AW
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic a_en_i,
    input wire logic a_we_i,
    input wire logic [AW-1:0] a_row_i,
    input wire logic [WIDTH-1:0] a_mask_i,
    input wire logic [WIDTH-1:0] a_wdat_i,
    output logic [WIDTH-1:0] a_rdat_o,
    input wire logic b_en_i,
    input wire logic b_we_i,
    input wire logic [AW-1:0] b_row_i,
    input wire logic [WIDTH-1:0] b_mask_i,
    input wire logic [WIDTH-1:0] b_wdat_i,
    output logic [WIDTH-1:0] b_rdat_o
);

    typedef struct packed {
        logic [WIDTH-1:0] ra;
        logic [WIDTH-1:0] rb;
    } cbr_mem_state_t;

    if (ROWS * WIDTH != CBR_TILE_BITS || (1 << AW) != ROWS) begin : g_bad_geometry
        $error("cbr_tile_mem: geometry does not match one tile");
    end

    logic [WIDTH-1:0] mem [ROWS];
    cbr_mem_state_t s_r;
    cbr_mem_state_t s_nxt;

    // Port B first so port A wins bits both write in one row
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (b_en_i && b_we_i && b_mask_i[i]) begin
                    mem[b_row_i][i] <= b_wdat_i[i];
                end
                if (a_en_i && a_we_i && a_mask_i[i]) begin
                    mem[a_row_i][i] <= a_wdat_i[i];
                end
            end
        end
    end

    // Read registers hold through writes, so writes never show
    always_comb begin
        s_nxt = s_r;
        if (a_en_i && !a_we_i) begin
            s_nxt.ra = mem[a_row_i];
        end
        if (b_en_i && !b_we_i) begin
            s_nxt.rb = mem[b_row_i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    assign a_rdat_o = s_r.ra;
    assign b_rdat_o = s_r.rb;

endmodule

// *** verification/cbr_fab_port.sv ***
/*
 Fabric-side user logic driving one port of the block RAM tile.
 Assumes the bench gives a one-cycle go pulse with the request beside it.
*/
`timescale 1ns/1ps
module cbr_fab_port (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [54:0] req_i,
    output logic en_o,
    output logic we_o,
    output logic [13:0] addr_o,
    output logic [35:0] din_o,
    output logic [3:0] be_o
);
    always_ff @(posedge clk_i) begin
        en_o <= go_i;
        if (go_i) begin
            {we_o, addr_o, din_o, be_o} <= req_i;
        end else begin
            // Idle fields toggle so a stale request never looks valid
            {we_o, addr_o, din_o, be_o} <= ~{we_o, addr_o, din_o, be_o};
        end
    end
endmodule

// *** verification/cbr_tile_asserts.sv ***
/*
 Concurrent checks on the Wishbone and fabric ports of the tile.
 Assumes one clock and no read in flight while the clock enable is low.
*/
`timescale 1ns/1ps
module cbr_tile_asserts
    import cbr_pkg::*;
#(
    parameter int DATA_W = CBR_ROW_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic a_en_i,
    input wire logic a_we_i,
    input wire logic [DATA_W-1:0] a_dout_o,
    input wire logic b_en_i,
    input wire logic b_we_i,
    input wire logic [DATA_W-1:0] b_dout_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");
    a_ack_answers_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("request not acked in one cycle");
    a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_unmapped_zero: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i > 32'h8) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_wbdat_holds: assert property (!$past(wb_cyc_i && wb_stb_i && !wb_ack_o) |-> $stable(wb_dat_o))
        else $error("read data moved without request");
    a_douta_reads_only: assert property ($changed(a_dout_o) |->
        $past(a_en_i && !a_we_i, 3) || $past(a_en_i && !a_we_i, 4))
        else $error("port A output moved without read");
    a_doutb_reads_only: assert property ($changed(b_dout_o) |->
        $past(b_en_i && !b_we_i, 3) || $past(b_en_i && !b_we_i, 4))
        else $error("port B output moved without read");
    a_reset_clears: assert property (disable iff (1'b0)
        rst_i |=> !wb_ack_o && a_dout_o == '0 && b_dout_o == '0)
        else $error("outputs not cleared by reset");
endmodule

bind cbr_tile cbr_tile_asserts #(.DATA_W(DATA_W)) cbr_tile_asserts_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .a_en_i(a_en_i), .a_we_i(a_we_i), .a_dout_o(a_dout_o),
    .b_en_i(b_en_i), .b_we_i(b_we_i), .b_dout_o(b_dout_o)
);

// *** verification/cbr_tile_tb.sv ***
/*
 Self-checking bench for the block RAM tile: Wishbone setup, two fabric ports.
 Assumes the fabric models issue one operation per go pulse.
*/
`timescale 1ns/1ps
module cbr_tile_tb;
    import cbr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic wwe = 1'b0;
    logic [31:0] wadr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] q;
    logic ga = 1'b0;
    logic gb = 1'b0;
    logic [54:0] ra = 55'h0;
    logic [54:0] rb = 55'h0;
    logic [15:0] w;
    logic [35:0] m = 36'h007FC01FF;
    logic [35:0] d1 = 36'h123456789;
    logic [35:0] d2 = 36'hFEDCBA987;
    int failures = 0;
    int samples_checked = 0;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o;
    wire logic a_en, a_we, b_en, b_we;
    wire logic [13:0] a_ad, b_ad;
    wire logic [35:0] a_d, b_d, a_dout, b_dout;
    wire logic [3:0] a_be, b_be;

    always #5 clk = ~clk;

    cbr_fab_port fa_i (.clk_i(clk), .go_i(ga), .req_i(ra), .en_o(a_en), .we_o(a_we),
        .addr_o(a_ad), .din_o(a_d), .be_o(a_be));
    cbr_fab_port fb_i (.clk_i(clk), .go_i(gb), .req_i(rb), .en_o(b_en), .we_o(b_we),
        .addr_o(b_ad), .din_o(b_d), .be_o(b_be));
    cbr_tile cbr_tile_i (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(wwe), .wb_adr_i(wadr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .a_en_i(a_en), .a_we_i(a_we), .a_addr_i(a_ad), .a_din_i(a_d),
        .a_be_i(a_be), .a_dout_o(a_dout), .b_en_i(b_en), .b_we_i(b_we), .b_addr_i(b_ad),
        .b_din_i(b_d), .b_be_i(b_be), .b_dout_o(b_dout));

    task chk(input logic [35:0] got, input logic [35:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
        cyc <= 1'b1;
        stb <= 1'b1;
        wwe <= we;
        wadr <= adr;
        wdat <= dat;
        @(posedge clk);
        while (wb_ack_o !== 1'b1) @(posedge clk);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task rr(input logic [31:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        chk({4'h0, q}, {4'h0, exp});
    endtask

    task go(input logic a, input logic b);
        ga <= a;
        gb <= b;
        @(posedge clk);
        ga <= 1'b0;
        gb <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    task rp(input logic b, input logic [13:0] ad, input logic [35:0] e);
        if (b) rb <= {1'b0, ad, 36'h0, 4'h0};
        else ra <= {1'b0, ad, 36'h0, 4'h0};
        go(!b, b);
        chk(b ? b_dout : a_dout, e);
    endtask

    task final_report;
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        final_report;
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rr(CBR_CTRL_OFS, 32'hB4);
        rr(CBR_STAT_OFS, 32'h0);
        rr(32'h10, 32'h0);
        for (int c = 0; c < 6; c++) begin
            wb(1'b1, CBR_CTRL_OFS, {24'h0, c[2:0], c[2:0], 2'h0});
            w = CBR_MAX_WORDS >> c;
            rr(CBR_INFO_OFS, {w, w});
        end
        ra <= {1'b1, 14'h5, d1, 4'hF};
        go(1'b1, 1'b0);
        rp(1'b0, 14'h5, d1);
        ra <= {1'b1, 14'h5, d2, 4'h5};
        go(1'b1, 1'b0);
        chk(a_dout, d1);
        rp(1'b0, 14'h5, (d2 & m) | (d1 & ~m));
        // Write offered while frozen must not land
        ce <= 1'b0;
        ra <= {1'b1, 14'h5, d1, 4'hF};
        go(1'b1, 1'b0);
        ce <= 1'b1;
        rp(1'b0, 14'h5, (d2 & m) | (d1 & ~m));
        wb(1'b1, CBR_CTRL_OFS, 32'h1B4);
        ra <= {1'b1, 14'h6, 36'hAAAAA5555, 4'hF};
        go(1'b1, 1'b0);
        rp(1'b0, 14'h6, 36'hAAAAA5555);
        wb(1'b1, CBR_CTRL_OFS, 32'h8D);
        ra <= {1'b1, 14'h0, 36'h1AB, 4'h0};
        go(1'b1, 1'b0);
        ra <= {1'b1, 14'h1, 36'h0CD, 4'h0};
        go(1'b1, 1'b0);
        rp(1'b1, 14'h0, 36'h19BAB);
        wb(1'b1, CBR_CTRL_OFS, 32'h4D);
        rp(1'b1, 14'h2, 36'hD);
        rp(1'b1, 14'h1, 36'hA);
        ra <= {1'b1, 14'h0, 36'h055, 4'h0};
        rb <= {1'b1, 14'h0, 36'h3, 4'h0};
        go(1'b1, 1'b1);
        rr(CBR_STAT_OFS, 32'h4);
        rp(1'b0, 14'h0, 36'h055);
        wb(1'b1, CBR_STAT_OFS, 32'h4);
        rr(CBR_STAT_OFS, 32'h0);
        wb(1'b1, CBR_CTRL_OFS, 32'h95);
        rr(CBR_STAT_OFS, 32'h1);
        ra <= {1'b1, 14'h0, 36'h1FF, 4'h0};
        go(1'b1, 1'b0);
        rr(CBR_STAT_OFS, 32'h3);
        wb(1'b1, CBR_STAT_OFS, 32'h2);
        rr(CBR_STAT_OFS, 32'h1);
        wb(1'b1, CBR_CTRL_OFS, 32'h8F);
        rr(CBR_STAT_OFS, 32'h1);
        wb(1'b1, CBR_CTRL_OFS, 32'h9C);
        rr(CBR_STAT_OFS, 32'h1);
        wb(1'b1, CBR_CTRL_OFS, 32'h8E);
        rr(CBR_STAT_OFS, 32'h0);
        rb <= {1'b1, 14'h0, 36'h3FFFF, 4'h3};
        go(1'b0, 1'b1);
        rr(CBR_STAT_OFS, 32'h2);
        rp(1'b1, 14'h0, 36'h19A55);
        rp(1'b0, 14'h1, 36'h055);
        final_report;
    end
endmodule
